// file: pair_decode_consts.vh
// Constants for the dual monitor address decode block
`ifndef PAIR_DECODE_CONSTS_VH
`define PAIR_DECODE_CONSTS_VH

// ****************************************
// Register map (AHB byte addresses)
// ****************************************
`define CTRL_ADDR 4'h0
`define STATUS_ADDR 4'h4
`define CTRL_RESET 4'h3
`define PORT_CTL_LO_BIT 0
`define PORT_CTL_HI_BIT 1
`define EXP_MODE_LSB 2

// ****************************************
// Port control codes
// ****************************************
`define PORT_ILLEGAL 2'h0
`define PORT_TERMINAL 2'h1
`define PORT_PRIMARY 2'h2
`define PORT_MANUAL 2'h3

// ****************************************
// Expansion modes
// ****************************************
`define EXP_NONE 2'h0
`define EXP_8K 2'h1
`define EXP_16K 2'h2

// ****************************************
// Address windows
// ****************************************
`define SRAM_SIZE_BITS 9
`define SCRATCH_BASE 16'ha000
`define SCRATCH_LAST 16'ha07f
`define ROM_BASE 16'he000
`define ROM_LAST 16'he3ff
`define SERIAL_BASE 16'h8008
`define SERIAL_LAST 16'h8009
`define UPORT_BASE 16'h8004
`define UPORT_LAST 16'h8007

// ****************************************
// Timing
// ****************************************
`define CLK_MHZ 200
`define RESET_PULSE_MS 4
`define RESET_PULSE_CYCLES (`RESET_PULSE_MS * `CLK_MHZ * 1000)

`endif

// file: dual_monitor_address_decode.v
// Address decode and monitor pair steering with AHB-Lite control registers
//
// What this block does
// - Top three address bits split memory into eight 8K blocks, selects active low.
// - Pattern 000 selects on-board 512-byte static RAM.
// - Patterns 001 and 010 select the two expansion RAM blocks.
// - Pattern 011 selects the user USER_HIGH_SELECT_A block at 6000.
// - Pattern 100 selects the I/O block holding the serial controller.
// - 101 scratch RAM, 110 second user USER_HIGH_SELECT_A, 111 monitor ROM.
// - Peripheral windows follow the fixed address map.
// - Optional 8K or 16K expansion moves static RAM to block 001 or 010, just above the expansion.
// - Read enable asserted for every processor read of off-board memory.
// - ROM and I/O selects go to exactly one monitor pair.
// - Switch position J picks primary pair, M the terminal pair.
// - Software port selection overrides switch at once, with no reset.
// - Every switch change gives a processor reset pulse of about 4 ms.
// - Manual latch changes while processor reset is asserted, or at once when a software port code hands back to manual.
// - Both pairs are never enabled together.
// - Push-button reset still resets the processor directly.
// - Port code 01 terminal, 10 primary, 11 manual, 00 illegal.
// - Port control bits read as ones after reset.
//
// Local design decisions: the AHB-Lite register port and the address map.
`include "pair_decode_consts.vh"

module dual_monitor_address_decode #(
  parameter RESET_PULSE_CYCLES = `RESET_PULSE_CYCLES,
  parameter CNT_W = 20
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  input wire [15:0] cpu_addr,
  input wire cpu_addr_valid,
  input wire cpu_read,
  input wire manual_pair_switch,
  input wire reset_button_n,
  output reg [7:0] block_sel_n,
  output reg sram_sel_n,
  output reg exp_ram_sel_n,
  output reg scratch_sel_n,
  output reg user_port_sel_n,
  output reg primary_rom_sel_n,
  output reg primary_serial_sel_n,
  output reg terminal_rom_sel_n,
  output reg terminal_serial_sel_n,
  output reg offboard_read_enable,
  output reg cpu_reset_n
);

  function in_win;
    input [15:0] a;
    input [15:0] lo;
    input [15:0] hi;
    begin
      in_win = (a >= lo) && (a <= hi);
    end
  endfunction

  // ****************************************
  // Register bus
  // ****************************************
  reg [3:0] ctrl_reg;
  reg wr_pend_reg;
  reg [3:0] wr_addr_reg;
  reg pair_select_control;
  reg pulse_active_reg;
  wire addr_phase = hsel && htrans[1] && hready;
  wire ctrl_wr = wr_pend_reg && (wr_addr_reg == `CTRL_ADDR);
  wire [3:0] ctrl_now = ctrl_wr ? hwdata[3:0] : ctrl_reg;
  wire [1:0] port_ctl = {ctrl_reg[`PORT_CTL_HI_BIT], ctrl_reg[`PORT_CTL_LO_BIT]};
  wire [1:0] exp_mode = ctrl_reg[`EXP_MODE_LSB +: 2];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= `CTRL_RESET;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 4'h0;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      // Writes outside the decoded page are dropped, as reads of it return zero
      wr_pend_reg <= addr_phase && hwrite && (haddr[31:4] == 28'h0);
      wr_addr_reg <= haddr[3:0];
      if (ctrl_wr) begin
        ctrl_reg <= hwdata[3:0];
      end
      if (addr_phase && !hwrite) begin
        if (haddr[31:4] != 28'h0) begin
          hrdata <= 32'h0;
        end else if (haddr[3:0] == `CTRL_ADDR) begin
          hrdata <= {28'h0, ctrl_now};
        end else if (haddr[3:0] == `STATUS_ADDR) begin
          hrdata <= {29'h0, pulse_active_reg, manual_pair_switch, pair_select_control};
        end else begin
          hrdata <= 32'h0;
        end
      end
    end
  end

  // ****************************************
  // Pair selection and reset pulse
  // ****************************************
  reg sw_prev_reg;
  reg init_done_reg;
  reg [CNT_W-1:0] pulse_cnt_reg;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_prev_reg <= 1'b0;
      init_done_reg <= 1'b0;
      pulse_cnt_reg <= {CNT_W{1'b0}};
      pulse_active_reg <= 1'b0;
      pair_select_control <= 1'b0;
    end else begin
      sw_prev_reg <= manual_pair_switch;
      init_done_reg <= 1'b1;
      if (!init_done_reg) begin
        // Switch level is caught after release, not under reset
        pair_select_control <= manual_pair_switch;
      end else if (manual_pair_switch != sw_prev_reg) begin
        pulse_active_reg <= 1'b1;
        pulse_cnt_reg <= RESET_PULSE_CYCLES[CNT_W-1:0] - 1'b1;
      end else if (pulse_active_reg) begin
        if (pulse_cnt_reg == {CNT_W{1'b0}}) begin
          pulse_active_reg <= 1'b0;
        end else begin
          pulse_cnt_reg <= pulse_cnt_reg - 1'b1;
        end
      end
      case (port_ctl)
        `PORT_TERMINAL: pair_select_control <= 1'b1;
        `PORT_PRIMARY: pair_select_control <= 1'b0;
        `PORT_MANUAL: begin
          // switch taken under reset, or once steady after hand-back
          if (init_done_reg && (pulse_active_reg || (manual_pair_switch == sw_prev_reg))) begin
            pair_select_control <= manual_pair_switch;
          end
        end
        default: pair_select_control <= pair_select_control;
      endcase
    end
  end

  // ****************************************
  // Address decode
  // ****************************************
  reg [7:0] blk_n;
  reg sram_hit;
  reg exp_hit;
  wire [2:0] top = cpu_addr[15:13];
  wire low_win = (cpu_addr[12:`SRAM_SIZE_BITS] == 4'h0);

  always @* begin
    blk_n = 8'hff;
    blk_n[top] = ~cpu_addr_valid;
    case (exp_mode)
      `EXP_8K: begin
        exp_hit = (top == 3'h0);
        sram_hit = (top == 3'h1) && low_win;
      end
      `EXP_16K: begin
        exp_hit = (top == 3'h0) || (top == 3'h1);
        sram_hit = (top == 3'h2) && low_win;
      end
      default: begin
        exp_hit = 1'b0;
        sram_hit = (top == 3'h0) && low_win;
      end
    endcase
  end

  wire rom_hit = in_win(cpu_addr, `ROM_BASE, `ROM_LAST);
  wire ser_hit = in_win(cpu_addr, `SERIAL_BASE, `SERIAL_LAST);
  // off-board is expansion space, fixed or remapped
  wire offboard = exp_hit || ((exp_mode == `EXP_NONE) && ((top == 3'h1) || (top == 3'h2)));

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      block_sel_n <= 8'hff;
      sram_sel_n <= 1'b1;
      exp_ram_sel_n <= 1'b1;
      scratch_sel_n <= 1'b1;
      user_port_sel_n <= 1'b1;
      primary_rom_sel_n <= 1'b1;
      primary_serial_sel_n <= 1'b1;
      terminal_rom_sel_n <= 1'b1;
      terminal_serial_sel_n <= 1'b1;
      offboard_read_enable <= 1'b0;
      cpu_reset_n <= 1'b0;
    end else begin
      block_sel_n <= blk_n;
      sram_sel_n <= ~(cpu_addr_valid && sram_hit);
      exp_ram_sel_n <= ~(cpu_addr_valid && exp_hit);
      scratch_sel_n <= ~(cpu_addr_valid && in_win(cpu_addr, `SCRATCH_BASE, `SCRATCH_LAST));
      user_port_sel_n <= ~(cpu_addr_valid && in_win(cpu_addr, `UPORT_BASE, `UPORT_LAST));
      primary_rom_sel_n <= ~(cpu_addr_valid && rom_hit && !pair_select_control);
      primary_serial_sel_n <= ~(cpu_addr_valid && ser_hit && !pair_select_control);
      terminal_rom_sel_n <= ~(cpu_addr_valid && rom_hit && pair_select_control);
      terminal_serial_sel_n <= ~(cpu_addr_valid && ser_hit && pair_select_control);
      offboard_read_enable <= cpu_addr_valid && cpu_read && offboard;
      cpu_reset_n <= reset_button_n && !pulse_active_reg && init_done_reg;
    end
  end

endmodule

// file: pair_decode_chk.sv
// Concurrent checks on decode and pair steering outputs
module pair_decode_chk (
  input wire hclk,
  input wire hresetn,
  input wire [15:0] cpu_addr,
  input wire cpu_addr_valid,
  input wire cpu_read,
  input wire manual_pair_switch,
  input wire reset_button_n,
  input wire [7:0] block_sel_n,
  input wire scratch_sel_n,
  input wire user_port_sel_n,
  input wire primary_rom_sel_n,
  input wire primary_serial_sel_n,
  input wire terminal_rom_sel_n,
  input wire terminal_serial_sel_n,
  input wire offboard_read_enable,
  input wire cpu_reset_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Properties
  // ****
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rom_hit;
    cpu_addr_valid && cpu_addr[15:10] == 6'h38;
  endsequence
  sequence serial_hit;
    cpu_addr_valid && cpu_addr[15:1] == 15'h4004;
  endsequence
  sequence sw_flip;
    $changed(manual_pair_switch);
  endsequence
  a_block_onehot: assert property (cpu_addr_valid |=> block_sel_n == ~(8'h01 << $past(cpu_addr[15:13])))
    else $error("block select not one-hot");
  a_block_idle: assert property (!cpu_addr_valid |=> block_sel_n == 8'hff)
    else $error("block select active without valid address");
  a_pair_exclusive: assert property ((primary_rom_sel_n | terminal_rom_sel_n) && (primary_serial_sel_n | terminal_serial_sel_n))
    else $error("both pairs selected");
  a_rom_steer: assert property (rom_hit |=> primary_rom_sel_n != terminal_rom_sel_n)
    else $error("monitor rom not steered to one pair");
  a_serial_steer: assert property (serial_hit |=> primary_serial_sel_n != terminal_serial_sel_n)
    else $error("serial select not steered to one pair");
  a_scratch_win: assert property (1'b1 |=> scratch_sel_n == !$past(cpu_addr_valid && cpu_addr[15:7] == 9'h140))
    else $error("scratch select outside its window");
  a_uport_win: assert property (1'b1 |=> user_port_sel_n == !$past(cpu_addr_valid && cpu_addr[15:2] == 14'h2001))
    else $error("user port select outside its window");
  a_read_gate: assert property (offboard_read_enable |-> $past(cpu_addr_valid && cpu_read))
    else $error("receive enable without a read");
  a_switch_pulse: assert property (sw_flip |-> ##[1:3] !cpu_reset_n)
    else $error("no processor reset after switch change");
  a_button_reset: assert property (!reset_button_n |-> ##[1:2] !cpu_reset_n)
    else $error("push button did not reset processor");
endmodule

bind dual_monitor_address_decode pair_decode_chk i_chk (.hclk, .hresetn, .cpu_addr, .cpu_addr_valid,
  .cpu_read, .manual_pair_switch, .reset_button_n, .block_sel_n, .scratch_sel_n, .user_port_sel_n,
  .primary_rom_sel_n, .primary_serial_sel_n, .terminal_rom_sel_n, .terminal_serial_sel_n,
  .offboard_read_enable, .cpu_reset_n);

// file: proc_bus_model.sv
// Processor bus model that issues addressed read and write cycles
module proc_bus_model (
  input wire hclk,
  output logic [15:0] cpu_addr,
  output logic cpu_addr_valid,
  output logic cpu_read
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Cycles
  // ****
  initial begin
    cpu_addr = 16'hffff;
    cpu_addr_valid = 1'b0;
    cpu_read = 1'b0;
  end
  // A cycle holds until the next one, as the processor keeps its address up
  task automatic put(input logic [15:0] a, input logic rd);
    @(posedge hclk);
    cpu_addr <= a;
    cpu_addr_valid <= 1'b1;
    cpu_read <= rd;
  endtask
endmodule

// file: tb_dual_monitor_address_decode.sv
// Self-checking bench for the dual monitor address decode block
`include "pair_decode_consts.vh"
module tb_dual_monitor_address_decode;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Setup
  // ****
  localparam int PULSE = 16;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic manual_pair_switch = 1'b0;
  logic reset_button_n = 1'b1;
  logic [31:0] rd;
  wire hreadyout;
  wire hresp;
  wire [31:0] hrdata;
  wire [15:0] cpu_addr;
  wire cpu_addr_valid;
  wire cpu_read;
  wire [7:0] block_sel_n;
  wire [8:0] sels;
  wire cpu_reset_n;
  int num_errors = 0;
  int checks_done = 0;
  always #2.5 hclk = ~hclk;
  proc_bus_model i_cpu (.hclk(hclk), .cpu_addr(cpu_addr), .cpu_addr_valid(cpu_addr_valid),
    .cpu_read(cpu_read));
  dual_monitor_address_decode #(.RESET_PULSE_CYCLES(PULSE)) i_dut (.hclk(hclk),
    .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .cpu_addr(cpu_addr), .cpu_addr_valid(cpu_addr_valid), .cpu_read(cpu_read),
    .manual_pair_switch(manual_pair_switch), .reset_button_n(reset_button_n),
    .block_sel_n(block_sel_n), .sram_sel_n(sels[8]), .exp_ram_sel_n(sels[7]),
    .scratch_sel_n(sels[6]), .user_port_sel_n(sels[5]), .primary_rom_sel_n(sels[4]),
    .primary_serial_sel_n(sels[3]), .terminal_rom_sel_n(sels[2]),
    .terminal_serial_sel_n(sels[1]), .offboard_read_enable(sels[0]), .cpu_reset_n(cpu_reset_n));
  // ****
  // Tasks
  // ****
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic probe(input logic [3:0] ctl, input logic [15:0] a, input logic r,
    input logic [8:0] exp);
    xfer(1'b1, `CTRL_ADDR, {28'h0, ctl});
    i_cpu.put(a, r);
    @(posedge hclk);
    @(negedge hclk);
    chk("selects", {23'h0, exp}, {23'h0, sels});
    chk("blocks", {24'h0, ~(8'h01 << a[15:13])}, {24'h0, block_sel_n});
  endtask
  // Switch flips at an edge; the pulse is counted over a fixed window
  task automatic flip(input logic s, input logic [8:0] exp);
    int n = 0;
    @(posedge hclk);
    manual_pair_switch <= s;
    repeat (40) begin
      @(negedge hclk);
      n += (cpu_reset_n === 1'b0);
    end
    chk("pulse length", PULSE, n);
    probe(4'h3, 16'he000, 1'b1, exp);
    xfer(1'b0, `STATUS_ADDR, 32'h0);
    chk("status", {29'h0, 1'b0, s, s}, rd);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ****
  // Tests
  // ****
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, `CTRL_ADDR, 32'h0);
    chk("ctrl", 32'h3, rd);
    xfer(1'b0, 32'h8, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("hresp", 32'h0, {31'h0, hresp});
    $display("test reset values done");
    probe(4'h3, 16'h0000, 1'b1, 9'h0fe);
    probe(4'h3, 16'h0200, 1'b1, 9'h1fe);
    probe(4'h3, 16'h2000, 1'b1, 9'h1ff);
    probe(4'h3, 16'h4000, 1'b0, 9'h1fe);
    probe(4'h3, 16'h6000, 1'b1, 9'h1fe);
    probe(4'h3, 16'h8004, 1'b1, 9'h1de);
    probe(4'h3, 16'h8009, 1'b1, 9'h1f6);
    probe(4'h3, 16'h800a, 1'b1, 9'h1fe);
    probe(4'h3, 16'ha07f, 1'b1, 9'h1be);
    probe(4'h3, 16'ha080, 1'b1, 9'h1fe);
    probe(4'h3, 16'hc000, 1'b1, 9'h1fe);
    probe(4'h3, 16'he3ff, 1'b1, 9'h1ee);
    probe(4'h3, 16'he400, 1'b1, 9'h1fe);
    probe(4'h7, 16'h0000, 1'b1, 9'h17f);
    probe(4'h7, 16'h2000, 1'b1, 9'h0fe);
    probe(4'hb, 16'h2000, 1'b1, 9'h17f);
    probe(4'hb, 16'h4000, 1'b1, 9'h0fe);
    $display("test decode done");
    probe(4'h1, 16'he000, 1'b1, 9'h1fa);
    probe(4'h0, 16'h8008, 1'b1, 9'h1fc);
    probe(4'h2, 16'he000, 1'b1, 9'h1ee);
    chk("cpu reset", 32'h1, {31'h0, cpu_reset_n});
    $display("test port override done");
    flip(1'b1, 9'h1fa);
    flip(1'b0, 9'h1ee);
    @(posedge hclk);
    reset_button_n <= 1'b0;
    repeat (3) @(negedge hclk);
    chk("button reset", 32'h0, {31'h0, cpu_reset_n});
    @(posedge hclk);
    reset_button_n <= 1'b1;
    $display("test switch and button done");
    xfer(1'b1, `CTRL_ADDR, 32'h1);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, `CTRL_ADDR, 32'h0);
    chk("ctrl after reset", 32'h3, rd);
    chk("cpu reset after reset", 32'h1, {31'h0, cpu_reset_n});
    $display("test mid-run reset done");
    close_out();
  end
  initial begin
    repeat (4000) @(posedge hclk);
    num_errors++;
    close_out();
  end
endmodule
